//--- acrb_pkg.sv
// Constants for the converter control register bank
// Behaviour
// - Global power-down stops channels, references, PLL, buffers
// - Channel A power-down bit stops only A
// - Channel B power-down bit stops only B
// - Software reset restores defaults, then self-clears
// - Clock gain field selects one of six steps
// - Pattern field picks normal or fixed test outputs
// - Code 101 outputs the assembled custom pattern
// - Custom low register gives output bits 10..0
// - Write effective within 100 ns of 16th edge
package acrb_pkg;
	// Serial frame layout
	localparam int FRAME_BITS = 16;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 11;
	localparam logic [4:0] FRAME_LAST = 5'h0F;
	// Register addresses
	localparam logic [4:0] ADDR_CTRL = 5'h00; // reset_power_reference_control
	localparam logic [4:0] ADDR_GAIN = 5'h04; // clock_buffer_gain
	localparam logic [4:0] ADDR_PAT = 5'h0A; // test_pattern_format_select
	localparam logic [4:0] ADDR_CUST_LO = 5'h0B; // custom_pattern_low
	localparam logic [4:0] ADDR_CUST_HI = 5'h0C;
	// Control register fields
	localparam int BIT_PDN_GLOBAL = 0;
	localparam int BIT_PDN_A = 2;
	localparam int BIT_PDN_B = 3;
	localparam int BIT_REF_EXT = 5;
	localparam int BIT_SW_RESET = 10;
	// Gain field position
	localparam int GAIN_LSB = 2;
	localparam int GAIN_MSB = 6;
	// Pattern register fields
	localparam int PAT_LSB = 5;
	localparam int PAT_MSB = 7;
	localparam int BIT_FORMAT = 9;
	// Custom upper field width
	localparam int CUST_HI_W = 5;
	// Reset values
	localparam logic [4:0] GAIN_RESET = 5'h00;
	localparam logic [2:0] PAT_RESET = 3'h0;
	// Clock gain codes
	localparam logic [4:0] GAIN_CODE_0 = 5'h18;
	localparam logic [4:0] GAIN_CODE_1 = 5'h00;
	localparam logic [4:0] GAIN_CODE_2 = 5'h0C;
	localparam logic [4:0] GAIN_CODE_3 = 5'h0A;
	localparam logic [4:0] GAIN_CODE_4 = 5'h09;
	localparam logic [4:0] GAIN_CODE_5 = 5'h08;
	localparam logic [2:0] GAIN_STEP_DEFAULT = 3'h1;
	// Test pattern codes
	localparam logic [2:0] PAT_NORMAL = 3'h0;
	localparam logic [2:0] PAT_ZEROS = 3'h1;
	localparam logic [2:0] PAT_ONES = 3'h2;
	localparam logic [2:0] PAT_TOGGLE = 3'h3;
	localparam logic [2:0] PAT_CUSTOM = 3'h5;
	localparam logic [2:0] PAT_DESKEW = 3'h6;
	localparam logic [2:0] PAT_SYNC = 3'h7;
	// Output word patterns
	localparam int WORD_W = 16;
	localparam logic [15:0] WORD_ZEROS = 16'h0000;
	localparam logic [15:0] WORD_ONES = 16'hFFFF;
	localparam logic [15:0] WORD_TOG_A = 16'hAAAA;
	localparam logic [15:0] WORD_TOG_B = 16'h5555;
	localparam logic [15:0] WORD_DESKEW = 16'hAAAA;
	localparam logic [15:0] WORD_SYNC_DEFAULT = 16'hFF00;
	localparam int CONV_W = 14;
	// Write latency budget
	localparam int CLK_PERIOD_NS = 4;
	localparam int WRITE_LATENCY_NS = 100;
	localparam int WRITE_LATENCY_CYC = WRITE_LATENCY_NS / CLK_PERIOD_NS;
endpackage

//--- acrb_serial_rx.sv
// Three-wire serial programming port receiver
`timescale 1ns/100ps
`default_nettype none
module acrb_serial_rx (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// Serial pins
	input wire logic i_sen_n,
	input wire logic i_sclk,
	input wire logic i_sdata,
	// Decoded write
	output logic o_wr_valid,
	output logic [4:0] o_wr_addr,
	output logic [10:0] o_wr_data
);
	// Synchroniser stages, first stage read only by second
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic sclk_prev_q; // Previous synced clock level
	logic [15:0] shift_q; // Frame shift register
	logic [4:0] count_q; // Bits received in this frame
	logic valid_q;
	logic [15:0] frame_q;
	wire sen_n_s = sync2_q[2];
	wire sclk_s = sync2_q[1];
	wire sdata_s = sync2_q[0];
	wire fall_edge = sclk_prev_q & ~sclk_s & ~sen_n_s; // Active falling edge
	wire last_bit = fall_edge & (count_q == acrb_pkg::FRAME_LAST);
	wire [15:0] shift_d = {shift_q[14:0], sdata_s};

	// Two-flop synchroniser for all pins
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
			sclk_prev_q <= 1'b1;
		end else begin
			sync1_q <= {i_sen_n, i_sclk, i_sdata};
			sync2_q <= sync1_q;
			sclk_prev_q <= sync2_q[1];
		end
	end

	// Shift bits on falling edges, address bits first
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			shift_q <= 16'h0000;
			count_q <= 5'h00;
		end else if (sen_n_s) begin
			count_q <= 5'h00; // Frame aborted or idle
		end else if (fall_edge) begin
			shift_q <= shift_d;
			count_q <= last_bit ? 5'h00 : count_q + 5'h01;
		end
	end

	// Emit the write at the 16th edge, well inside the budget
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			valid_q <= 1'b0;
			frame_q <= 16'h0000;
		end else begin
			valid_q <= last_bit;
			if (last_bit) begin
				frame_q <= shift_d;
			end
		end
	end

	assign o_wr_valid = valid_q;
	assign o_wr_addr = frame_q[15:11];
	assign o_wr_data = frame_q[10:0];

	// Write must appear one cycle after the last edge
	property p_write_latency;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		last_bit |-> ##1 o_wr_valid;
	endproperty
	a_write_latency: assert property (p_write_latency) else $error("write not issued after last bit");
endmodule
`default_nettype wire

//--- acrb_top.sv
// Converter control register bank with test-pattern output selection
`timescale 1ns/100ps
`default_nettype none
module acrb_top #(
	parameter logic [15:0] SYNC_WORD = acrb_pkg::WORD_SYNC_DEFAULT
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// Serial programming port
	input wire logic i_sen_n,
	input wire logic i_sclk,
	input wire logic i_sdata,
	// Conversion data, two's complement, one word per strobe
	input wire logic i_word_strobe,
	input wire logic [13:0] i_conv_a,
	input wire logic [13:0] i_conv_b,
	// Power and reference controls
	output logic o_pdn_adc_a,
	output logic o_pdn_adc_b,
	output logic o_pdn_ref,
	output logic o_pdn_pll,
	output logic o_pdn_outbuf,
	output logic o_ref_external,
	// Clock buffer gain
	output logic [4:0] o_clk_gain_code,
	output logic [2:0] o_clk_gain_step,
	// Output selection
	output logic [2:0] o_pattern_sel,
	output logic o_output_format_bit,
	output logic [15:0] o_custom_word,
	output logic [15:0] o_data_a,
	output logic [15:0] o_data_b,
	// Software reset pulse
	output logic o_soft_reset
);
	// Decoded write from the serial port
	logic wr_valid;
	logic [4:0] wr_addr;
	logic [10:0] wr_data;

	// Stored register fields
	logic pdn_global_q;
	logic pdn_a_q; // Channel A down, global bit folded in
	logic pdn_b_q; // Channel B down, global bit folded in
	logic ref_ext_q;
	logic [4:0] gain_q;
	logic [2:0] pat_q;
	logic format_q;
	logic [10:0] cust_lo_q;
	logic [4:0] cust_hi_q;
	logic soft_reset_q;
	// Output-facing flops
	logic [2:0] gain_step_q;
	logic toggle_q; // Toggle pattern phase
	logic [15:0] data_a_q;
	logic [15:0] data_b_q;

	// Serial receiver
	acrb_serial_rx u_rx (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_sen_n(i_sen_n),
		.i_sclk(i_sclk),
		.i_sdata(i_sdata),
		.o_wr_valid(wr_valid),
		.o_wr_addr(wr_addr),
		.o_wr_data(wr_data)
	);

	// Map a gain code to its step, unknown codes as the default step
	function automatic logic [2:0] gain_step(input logic [4:0] code);
		logic [2:0] step;
		step = acrb_pkg::GAIN_STEP_DEFAULT;
		if (code == acrb_pkg::GAIN_CODE_0) begin
			step = 3'h0;
		end else if (code == acrb_pkg::GAIN_CODE_2) begin
			step = 3'h2;
		end else if (code == acrb_pkg::GAIN_CODE_3) begin
			step = 3'h3;
		end else if (code == acrb_pkg::GAIN_CODE_4) begin
			step = 3'h4;
		end else if (code == acrb_pkg::GAIN_CODE_5) begin
			step = 3'h5;
		end
		return step;
	endfunction

	// Address decode
	wire wr_ctrl = wr_valid && (wr_addr == acrb_pkg::ADDR_CTRL);
	wire wr_gain = wr_valid && (wr_addr == acrb_pkg::ADDR_GAIN);
	wire wr_pat = wr_valid && (wr_addr == acrb_pkg::ADDR_PAT);
	wire wr_lo = wr_valid && (wr_addr == acrb_pkg::ADDR_CUST_LO);
	wire wr_hi = wr_valid && (wr_addr == acrb_pkg::ADDR_CUST_HI);
	wire sw_reset = wr_ctrl && wr_data[acrb_pkg::BIT_SW_RESET];

	// Custom word, upper register above lower
	wire [15:0] custom_word = {cust_hi_q, cust_lo_q};

	// Conversion words, straight binary flips the sign bit
	wire [13:0] fmt_mask = {format_q, 13'h0000};
	wire [15:0] conv_a = {2'b00, i_conv_a ^ fmt_mask};
	wire [15:0] conv_b = {2'b00, i_conv_b ^ fmt_mask};

	// Pattern word for both channels
	wire [15:0] tog_word = toggle_q ? acrb_pkg::WORD_TOG_B : acrb_pkg::WORD_TOG_A;
	wire pat_fixed = (pat_q != acrb_pkg::PAT_NORMAL) && (pat_q != 3'h4);
	wire [15:0] pat_word =
		(pat_q == acrb_pkg::PAT_ZEROS) ? acrb_pkg::WORD_ZEROS :
		(pat_q == acrb_pkg::PAT_ONES) ? acrb_pkg::WORD_ONES :
		(pat_q == acrb_pkg::PAT_TOGGLE) ? tog_word :
		(pat_q == acrb_pkg::PAT_CUSTOM) ? custom_word :
		(pat_q == acrb_pkg::PAT_DESKEW) ? acrb_pkg::WORD_DESKEW : SYNC_WORD;
	wire [15:0] data_a_d = pat_fixed ? pat_word : conv_a;
	wire [15:0] data_b_d = pat_fixed ? pat_word : conv_b;

	// Control register: power and reference; reset bit never stored
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pdn_global_q <= 1'b0;
			pdn_a_q <= 1'b0;
			pdn_b_q <= 1'b0;
			ref_ext_q <= 1'b0;
		end else if (sw_reset) begin
			pdn_global_q <= 1'b0;
			pdn_a_q <= 1'b0;
			pdn_b_q <= 1'b0;
			ref_ext_q <= 1'b0;
		end else if (wr_ctrl) begin
			pdn_global_q <= wr_data[acrb_pkg::BIT_PDN_GLOBAL];
			// Global bit folded in here so each channel pin leaves a flop
			pdn_a_q <= wr_data[acrb_pkg::BIT_PDN_GLOBAL] | wr_data[acrb_pkg::BIT_PDN_A];
			pdn_b_q <= wr_data[acrb_pkg::BIT_PDN_GLOBAL] | wr_data[acrb_pkg::BIT_PDN_B];
			ref_ext_q <= wr_data[acrb_pkg::BIT_REF_EXT];
		end
	end

	// Gain and pattern registers
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			gain_q <= acrb_pkg::GAIN_RESET;
			pat_q <= acrb_pkg::PAT_RESET;
			format_q <= 1'b0;
		end else if (sw_reset) begin
			gain_q <= acrb_pkg::GAIN_RESET;
			pat_q <= acrb_pkg::PAT_RESET;
			format_q <= 1'b0;
		end else begin
			if (wr_gain) begin
				gain_q <= wr_data[acrb_pkg::GAIN_MSB:acrb_pkg::GAIN_LSB];
			end
			if (wr_pat) begin
				pat_q <= wr_data[acrb_pkg::PAT_MSB:acrb_pkg::PAT_LSB];
				format_q <= wr_data[acrb_pkg::BIT_FORMAT];
			end
		end
	end

	// Custom pattern registers
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cust_lo_q <= 11'h000;
			cust_hi_q <= 5'h00;
		end else if (sw_reset) begin
			cust_lo_q <= 11'h000;
			cust_hi_q <= 5'h00;
		end else begin
			if (wr_lo) begin
				cust_lo_q <= wr_data;
			end
			if (wr_hi) begin
				cust_hi_q <= wr_data[acrb_pkg::CUST_HI_W-1:0];
			end
		end
	end

	// Output flops: reset pulse, gain step, pattern phase, data
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			soft_reset_q <= 1'b0;
			gain_step_q <= acrb_pkg::GAIN_STEP_DEFAULT;
			toggle_q <= 1'b0;
			data_a_q <= 16'h0000;
			data_b_q <= 16'h0000;
		end else begin
			soft_reset_q <= sw_reset; // One cycle, self-clearing
			gain_step_q <= gain_step(gain_q);
			if (i_word_strobe) begin
				toggle_q <= ~toggle_q;
			end
			data_a_q <= data_a_d;
			data_b_q <= data_b_d;
		end
	end

	// Power controls, global one already folded into each channel
	assign o_pdn_adc_a = pdn_a_q;
	assign o_pdn_adc_b = pdn_b_q;
	assign o_pdn_ref = pdn_global_q;
	assign o_pdn_pll = pdn_global_q;
	assign o_pdn_outbuf = pdn_global_q;
	assign o_ref_external = ref_ext_q;
	assign o_clk_gain_code = gain_q;
	assign o_clk_gain_step = gain_step_q;
	assign o_pattern_sel = pat_q;
	assign o_output_format_bit = format_q;
	assign o_custom_word = custom_word;
	assign o_data_a = data_a_q;
	assign o_data_b = data_b_q;
	assign o_soft_reset = soft_reset_q;

	// Global power-down write reaches every block the next cycle
	property p_global_pdn;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(wr_ctrl && !sw_reset) |=> (o_pdn_pll == $past(wr_data[0])) && (o_pdn_adc_a || !$past(wr_data[0]))
			&& (o_pdn_ref == $past(wr_data[0])) && (o_pdn_outbuf == $past(wr_data[0]))
			&& (o_pdn_adc_b || !$past(wr_data[0]));
	endproperty
	a_global_pdn: assert property (p_global_pdn) else $error("global power-down not applied");

	// Channel A is down after a write with its own bit or the global bit set
	property p_pdn_a;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(wr_ctrl && !sw_reset) |=> (o_pdn_adc_a == ($past(wr_data[0]) || $past(wr_data[2])));
	endproperty
	a_pdn_a: assert property (p_pdn_a) else $error("channel A power-down wrong");

	// Channel B follows its own bit when global is clear
	property p_pdn_b;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(wr_ctrl && !sw_reset && !wr_data[0]) |=> (o_pdn_adc_b == $past(wr_data[3])) && (o_pdn_adc_a == $past(wr_data[2]));
	endproperty
	a_pdn_b: assert property (p_pdn_b) else $error("channel B power-down wrong");

	// Software reset restores defaults and pulses once
	property p_sw_reset;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		sw_reset |=> o_soft_reset && (o_pattern_sel == 3'h0) && (o_clk_gain_code == 5'h00) && !o_pdn_pll
			##1 !o_soft_reset || $past(sw_reset);
	endproperty
	a_sw_reset: assert property (p_sw_reset) else $error("software reset did not restore defaults");

	// Gain step two cycles after a gain write
	property p_gain;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(wr_gain && !sw_reset && wr_data[6:2] == 5'h08) |=> ##1 o_clk_gain_step == 3'h5;
	endproperty
	a_gain: assert property (p_gain) else $error("maximum gain code not decoded");

	// All-ones pattern replaces conversion data
	property p_ones;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(pat_q == 3'h2) |=> (o_data_a == 16'hFFFF) && (o_data_b == 16'hFFFF);
	endproperty
	a_ones: assert property (p_ones) else $error("all-ones pattern not output");

	// Custom pattern output
	property p_custom;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(pat_q == 3'h5) |=> o_data_a == $past({cust_hi_q, cust_lo_q});
	endproperty
	a_custom: assert property (p_custom) else $error("custom pattern not output");

	// Low custom write lands in bits 10..0
	property p_cust_lo;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(wr_lo) |=> o_custom_word[10:0] == $past(wr_data);
	endproperty
	a_cust_lo: assert property (p_cust_lo) else $error("custom low bits misplaced");

	// Straight binary flips only the sign bit in normal mode
	property p_format;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(pat_q == 3'h0 && format_q) |=> o_data_a[13:0] == ($past(i_conv_a) ^ 14'h2000);
	endproperty
	a_format: assert property (p_format) else $error("straight binary format wrong");
endmodule
`default_nettype wire

//--- acrb_host_model.sv
// Host model that writes frames on the serial programming port
`timescale 1ns/100ps
`default_nettype none
module acrb_host_model #(
	parameter int HALF_CYC = 7
) (
	// System clock, used only to pace the pins
	input wire logic i_clk_sys,
	// Serial pins toward the device
	output logic o_sen_n,
	output logic o_sclk,
	output logic o_sdata
);
	// Idle: deselected, clock parked high
	initial begin
		o_sen_n = 1'b1;
		o_sclk = 1'b1;
		o_sdata = 1'b0;
	end

	// One sclk level; 28 ns keeps sclk under 20 MHz and covers setup and hold
	task automatic hold_level();
		repeat (HALF_CYC) @(negedge i_clk_sys);
	endtask

	// One frame, address then data, most significant bit first; returns one level after the 16th fall
	task automatic send(input logic [4:0] addr, input logic [10:0] data);
		logic [15:0] word;
		word = {addr, data};
		@(negedge i_clk_sys);
		o_sen_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			o_sdata = word[i];
			hold_level();
			o_sclk = 1'b0;
			hold_level();
			o_sclk = 1'b1;
		end
		o_sen_n = 1'b1;
		// Released line shows the inverse, so stale data cannot pass as valid
		o_sdata = ~word[0];
	endtask
endmodule
`default_nettype wire

//--- acrb_top_test.sv
// Self-checking testbench of the converter control register bank
`timescale 1ns/100ps
`default_nettype none
module acrb_top_test;
	localparam int LIMIT = 40000;
	localparam logic [15:0] SYNC = 16'h3C5A;
	// Clock, reset and stimulus
	logic i_clk_sys, i_resetn, sen_n, sclk, sdata, i_word_strobe;
	logic [13:0] i_conv_a, i_conv_b;
	// Observed outputs
	logic o_pdn_adc_a, o_pdn_adc_b, o_pdn_ref, o_pdn_pll, o_pdn_outbuf, o_ref_external;
	logic o_output_format_bit, o_soft_reset;
	logic [4:0] o_clk_gain_code;
	logic [2:0] o_clk_gain_step, o_pattern_sel;
	logic [15:0] o_custom_word, o_data_a, o_data_b;
	// Bookkeeping
	int n_fail = 0, compares = 0, cyc = 0, n_pulse = 0;
	logic [31:0] seed = 32'hABD13ADD;
	logic [15:0] cust;
	logic [4:0] gcode [0:6] = '{5'h18, 5'h00, 5'h0C, 5'h0A, 5'h09, 5'h08, 5'h1F};

	acrb_host_model host_u (.i_clk_sys(i_clk_sys), .o_sen_n(sen_n), .o_sclk(sclk), .o_sdata(sdata));

	acrb_top #(.SYNC_WORD(SYNC)) dut_u (
		.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_sen_n(sen_n), .i_sclk(sclk), .i_sdata(sdata),
		.i_word_strobe(i_word_strobe), .i_conv_a(i_conv_a), .i_conv_b(i_conv_b),
		.o_pdn_adc_a(o_pdn_adc_a), .o_pdn_adc_b(o_pdn_adc_b), .o_pdn_ref(o_pdn_ref), .o_pdn_pll(o_pdn_pll),
		.o_pdn_outbuf(o_pdn_outbuf), .o_ref_external(o_ref_external), .o_clk_gain_code(o_clk_gain_code),
		.o_clk_gain_step(o_clk_gain_step), .o_pattern_sel(o_pattern_sel),
		.o_output_format_bit(o_output_format_bit), .o_custom_word(o_custom_word),
		.o_data_a(o_data_a), .o_data_b(o_data_b), .o_soft_reset(o_soft_reset));

	// 250 MHz clock
	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end

	// Galois shift register for repeatable random values
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return (s >> 1) ^ (s[0] ? 32'hD0000001 : 32'h00000000);
	endfunction

	// Expected output word for a pattern code
	function automatic logic [15:0] exp_word(input logic [2:0] pat, input logic fmt, input logic [13:0] conv,
		input logic [15:0] cw, input logic tog);
		case (pat)
			3'h1: return 16'h0000;
			3'h2: return 16'hFFFF;
			3'h3: return tog ? 16'h5555 : 16'hAAAA;
			3'h5: return cw;
			3'h6: return 16'hAAAA;
			3'h7: return SYNC;
			default: return {2'b00, conv[13] ^ fmt, conv[12:0]};
		endcase
	endfunction

	// Value compare, counted
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			n_fail++;
		end
	endtask

	// Verdict and end of run
	task automatic results();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// One register write, then wait out the 25-cycle budget after the 16th fall
	task automatic wr(input logic [4:0] a, input logic [10:0] d);
		host_u.send(a, d);
		repeat (18) @(negedge i_clk_sys);
	endtask

	// Reset-state outputs
	task automatic chk_defaults();
		chk("pdn_a", 16'h0, o_pdn_adc_a);
		chk("pdn_b", 16'h0, o_pdn_adc_b);
		chk("pdn_pll", 16'h0, o_pdn_pll);
		chk("ref_ext", 16'h0, o_ref_external);
		chk("format", 16'h0, o_output_format_bit);
		chk("gain_code", 16'h0, o_clk_gain_code);
		chk("gain_step", 16'h1, o_clk_gain_step);
		chk("pattern", 16'h0, o_pattern_sel);
		chk("custom", 16'h0, o_custom_word);
	endtask

	// New conversion words, then both data outputs
	task automatic chk_data(input logic [2:0] p, input logic f, input logic tog);
		seed = lfsr_next(seed);
		i_conv_a = seed[13:0];
		i_conv_b = seed[29:16];
		repeat (3) @(negedge i_clk_sys);
		chk("data_a", exp_word(p, f, i_conv_a, cust, tog), o_data_a);
		chk("data_b", exp_word(p, f, i_conv_b, cust, tog), o_data_b);
	endtask

	// Software reset pulses seen, and the hang limit
	always @(negedge i_clk_sys) begin
		if (o_soft_reset === 1'b1) n_pulse++;
		cyc++;
		if (cyc == LIMIT) begin
			n_fail++;
			results();
		end
	end

	initial begin
		i_resetn = 1'b0;
		i_word_strobe = 1'b0;
		i_conv_a = 14'h0000;
		i_conv_b = 14'h0000;
		cust = 16'h0000;
		repeat (6) @(negedge i_clk_sys);
		i_resetn = 1'b1;
		repeat (2) @(negedge i_clk_sys);
		chk_defaults();
		$display("test reset done");
		// Every power-down and reference combination; unused bits written as zero
		for (int i = 0; i < 16; i++) begin
			wr(acrb_pkg::ADDR_CTRL, {5'h00, i[3], 1'b0, i[2], i[1], 1'b0, i[0]});
			chk("pdn_a", 16'(i[0] | i[1]), o_pdn_adc_a);
			chk("pdn_b", 16'(i[0] | i[2]), o_pdn_adc_b);
			chk("pdn_ref", 16'(i[0]), o_pdn_ref);
			chk("pdn_pll", 16'(i[0]), o_pdn_pll);
			chk("pdn_buf", 16'(i[0]), o_pdn_outbuf);
			chk("ref_ext", 16'(i[3]), o_ref_external);
		end
		$display("test power done");
		// Each gain code, then an undefined one
		for (int i = 0; i < 7; i++) begin
			wr(acrb_pkg::ADDR_GAIN, {4'h0, gcode[i], 2'b00});
			chk("gain_code", 16'(gcode[i]), o_clk_gain_code);
			chk("gain_step", (i < 6) ? 16'(i) : 16'h1, o_clk_gain_step);
		end
		// Unmapped address must leave the gain alone
		seed = lfsr_next(seed);
		wr(5'h05, seed[10:0]);
		chk("gain_code", 16'h1F, o_clk_gain_code);
		$display("test gain done");
		// Custom word from low and upper registers
		seed = lfsr_next(seed);
		cust = {seed[20:16], seed[10:0]};
		wr(acrb_pkg::ADDR_CUST_LO, cust[10:0]);
		wr(acrb_pkg::ADDR_CUST_HI, {6'h00, cust[15:11]});
		chk("custom", cust, o_custom_word);
		// Every pattern code in both data formats
		for (int p = 0; p < 8; p++) begin
			for (int f = 0; f < 2; f++) begin
				wr(acrb_pkg::ADDR_PAT, {1'b0, f[0], 1'b0, p[2:0], 5'h00});
				chk("pattern", 16'(p), o_pattern_sel);
				chk("format", 16'(f), o_output_format_bit);
				chk_data(p[2:0], f[0], 1'b0);
			end
		end
		// Toggle pattern flips phase on a word strobe
		wr(acrb_pkg::ADDR_PAT, 11'h060);
		i_word_strobe = 1'b1;
		@(negedge i_clk_sys);
		i_word_strobe = 1'b0;
		chk_data(3'h3, 1'b0, 1'b1);
		$display("test pattern done");
		// Software reset restores defaults and ignores the rest of its write
		wr(acrb_pkg::ADDR_CTRL, 11'h02D);
		wr(acrb_pkg::ADDR_CTRL, 11'h401);
		chk_defaults();
		chk("pulses", 16'h1, 16'(n_pulse));
		// Self-cleared: a later plain write is stored and no new pulse appears
		wr(acrb_pkg::ADDR_CTRL, 11'h004);
		chk("pdn_a", 16'h1, o_pdn_adc_a);
		chk("pulses", 16'h1, 16'(n_pulse));
		$display("test soft reset done");
		results();
	end
endmodule
`default_nettype wire
